/* File: rtl/gpio_pkg.sv */
// constants, register map and carrier types of the shared-pin gpio block
// assumes one core clock and a 32-bit classic wishbone register bus
package gpio_pkg;

  // ----------------------------------------------------------------
  // pins and groups
  // ----------------------------------------------------------------
  localparam int PAD_COUNT      = 37;
  localparam int LOGICAL_COUNT  = 41;
  localparam int GROUP_COUNT    = 5;
  localparam int HOST_EN_BIT    = 16;
  localparam int SHARED_C_PAD   = 24;
  localparam int SHARED_E_LO    = 36;
  localparam int SHARED_COUNT   = 4;
  localparam int TIMER_PAD      = 36;
  localparam int TIMER_BIT      = 40;
  localparam logic [15:0] HOST_FREE_MASK = 16'hE600;

  // group order: host port, group c, group d, group e, timer
  localparam int GRP_LO [GROUP_COUNT] = '{0, 16, 28, 30, 40};
  localparam logic [31:0] GRP_MASK [GROUP_COUNT] =
    '{32'h0000FFFF, 32'h00000FFF, 32'h00000003, 32'h000003FF, 32'h00000001};

  // ----------------------------------------------------------------
  // register map: group base in adr[6:4], kind in adr[3:2]
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam logic [6:0] HOST_PORT_CONTROL_REG_OFF        = 7'h00;
  localparam logic [6:0] HOST_PORT_GPIO_DIRECTION_REG_OFF = 7'h04;
  localparam logic [6:0] HOST_PORT_GPIO_DATA_REG_OFF      = 7'h08;
  localparam logic [6:0] GROUP_C_CONTROL_REG_OFF          = 7'h10;
  localparam logic [6:0] GROUP_C_DIRECTION_REG_OFF        = 7'h14;
  localparam logic [6:0] GROUP_C_DATA_REG_OFF             = 7'h18;
  localparam logic [6:0] GROUP_D_CONTROL_REG_OFF          = 7'h20;
  localparam logic [6:0] GROUP_E_CONTROL_REG_OFF          = 7'h30;
  localparam logic [6:0] TIMER_CONTROL_REG_OFF            = 7'h40;
  localparam logic [6:0] TIMER_DIRECTION_REG_OFF          = 7'h44;
  localparam logic [6:0] TIMER_DATA_REG_OFF               = 7'h48;
  localparam logic [1:0] KIND_CTRL = 2'h0;
  localparam logic [1:0] KIND_DIR  = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        host_en;
    logic [15:0] host_allow;
    logic [24:0] ctrl;
    logic [40:0] dir;
    logic [40:0] data;
  } gpio_regs_type;

  localparam gpio_regs_type REGS_RESET = '0;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [6:0]  adr;
    logic [31:0] dat;
  } wb_req_type;

endpackage : gpio_pkg

/* File: rtl/shared_pin_gpio_ports.sv */
// shared-pin gpio ports: five groups of pads muxed between peripherals and gpio
// assumes pad inputs synchronous to i_core_clk and a classic wishbone master
//
// Overview of operation
// - 37 pads, each peripheral or gpio
// - every gpio pad shared with a peripheral
// - all pads gpio after reset
// - five groups, each controlled independently
// - host port group: 16 gpio pads
// - group c: 12 pads, first audio port
// - group d: 2 pads, audio transmitter
// - group e: 10 pins, second audio port
// - timer group: one pad, timer signal
// - host port off: all 16 gpio
// - host port on: only five may be gpio
// - host group: control, data, direction registers
// - group c pads individually selectable as gpio
// - group c: control, direction, data registers
// - four e pins share group c pads
module shared_pin_gpio_ports (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst,
  input  wire gpio_pkg::wb_req_type       i_wb,
  output logic                            o_wb_ack,
  output logic [31:0]                     o_wb_dat,
  input  wire logic [36:0]                i_pad_in,
  output logic [36:0]                     o_pad_out,
  output logic [36:0]                     o_pad_oe_n,
  input  wire logic [36:0]                i_periph_out,
  input  wire logic [36:0]                i_periph_oe_n,
  input  wire logic [3:0]                 i_second_shared_out,
  input  wire logic [3:0]                 i_second_shared_oe_n,
  output logic [36:0]                     o_periph_in,
  output logic [3:0]                      o_second_shared_in,
  output logic [40:0]                     o_periph_sel
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  gpio_pkg::gpio_regs_type regs_q;
  gpio_pkg::gpio_regs_type regs_d;
  logic                    ack_q;
  logic                    ack_d;
  logic [31:0]             rdat_q;
  logic [31:0]             rdat_d;
  logic [40:0]             periph_sel;
  logic [40:0]             level;
  logic [36:0]             pad_out_d;
  logic [36:0]             pad_oe_n_d;

  // logical pin level seen by gpio reads
  assign level = {o_periph_in[36], o_periph_in[27:24], o_periph_in[35:0]};

  // host pads go to the host port while host_en is set, unless released by software
  assign periph_sel = {regs_q.ctrl,
                       regs_q.host_en ? ~regs_q.host_allow : 16'h0000};

  // ----------------------------------------------------------------
  // bus slave and register next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] wmask;
    logic [40:0] ctrl_v;
    logic [40:0] fmask;
    logic [40:0] wide;
    logic [40:0] rd_v;
    logic        req;
    wmask  = {{8{i_wb.sel[3]}}, {8{i_wb.sel[2]}}, {8{i_wb.sel[1]}}, {8{i_wb.sel[0]}}};
    ctrl_v = {regs_q.ctrl, 16'h0000};
    fmask  = '0;
    wide   = '0;
    rd_v   = '0;
    regs_d = regs_q;
    req    = i_wb.cyc & i_wb.stb & ~ack_q;
    ack_d  = req;
    rdat_d = gpio_pkg::UNMAPPED_READ;
    if (req && i_wb.adr[1:0] == 2'h0) begin
      for (int g = 0; g < gpio_pkg::GROUP_COUNT; g++) begin
        if (i_wb.adr[6:4] == 3'(g)) begin
          fmask = 41'(gpio_pkg::GRP_MASK[g] & wmask) << gpio_pkg::GRP_LO[g];
          wide  = 41'(i_wb.dat) << gpio_pkg::GRP_LO[g];
          unique case (i_wb.adr[3:2])
            gpio_pkg::KIND_CTRL: begin
              if (g == 0) begin
                rdat_d = {15'h0000, regs_q.host_en, regs_q.host_allow};
                if (i_wb.we && i_wb.sel[2]) begin
                  regs_d.host_en = i_wb.dat[gpio_pkg::HOST_EN_BIT];
                end
                if (i_wb.we) begin
                  regs_d.host_allow = (regs_q.host_allow & ~wmask[15:0])
                    | (i_wb.dat[15:0] & wmask[15:0] & gpio_pkg::HOST_FREE_MASK);
                end
              end else begin
                rd_v   = ctrl_v >> gpio_pkg::GRP_LO[g];
                rdat_d = rd_v[31:0] & gpio_pkg::GRP_MASK[g];
                if (i_wb.we) begin
                  ctrl_v      = (ctrl_v & ~fmask) | (wide & fmask);
                  regs_d.ctrl = ctrl_v[40:16];
                end
              end
            end
            gpio_pkg::KIND_DIR: begin
              rd_v   = regs_q.dir >> gpio_pkg::GRP_LO[g];
              rdat_d = rd_v[31:0] & gpio_pkg::GRP_MASK[g];
              if (i_wb.we) begin
                regs_d.dir = (regs_q.dir & ~fmask) | (wide & fmask);
              end
            end
            gpio_pkg::KIND_DATA: begin
              rd_v   = ((regs_q.data & regs_q.dir) | (level & ~regs_q.dir))
                       >> gpio_pkg::GRP_LO[g];
              rdat_d = rd_v[31:0] & gpio_pkg::GRP_MASK[g];
              if (i_wb.we) begin
                regs_d.data = (regs_q.data & ~fmask) | (wide & fmask);
              end
            end
            default: begin
              rdat_d = gpio_pkg::UNMAPPED_READ;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      regs_q <= gpio_pkg::REGS_RESET;
      ack_q  <= 1'b0;
      rdat_q <= '0;
    end else begin
      regs_q <= regs_d;
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  // ----------------------------------------------------------------
  // pad multiplexing
  // ----------------------------------------------------------------
  for (genvar p = 0; p < gpio_pkg::PAD_COUNT; p++) begin : g_pad
    localparam int L = (p == gpio_pkg::TIMER_PAD) ? gpio_pkg::TIMER_BIT : p;
    if (p >= gpio_pkg::SHARED_C_PAD && p < gpio_pkg::SHARED_C_PAD + gpio_pkg::SHARED_COUNT)
    begin : g_shared
      localparam int K = p - gpio_pkg::SHARED_C_PAD;
      localparam int E = gpio_pkg::SHARED_E_LO + K;
      // first port, then second port, then group c gpio, then group e gpio
      assign pad_out_d[p] = periph_sel[L] ? i_periph_out[p]
                          : periph_sel[E] ? i_second_shared_out[K]
                          : regs_q.dir[L] ? regs_q.data[L]
                          : regs_q.data[E];
      assign pad_oe_n_d[p] = periph_sel[L] ? i_periph_oe_n[p]
                           : periph_sel[E] ? i_second_shared_oe_n[K]
                           : ~(regs_q.dir[L] | regs_q.dir[E]);
    end else begin : g_plain
      assign pad_out_d[p]  = periph_sel[L] ? i_periph_out[p] : regs_q.data[L];
      assign pad_oe_n_d[p] = periph_sel[L] ? i_periph_oe_n[p] : ~regs_q.dir[L];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pad_out          <= '0;
      o_pad_oe_n         <= '1;
      o_periph_in        <= '0;
      o_second_shared_in <= '0;
      o_periph_sel       <= '0;
    end else begin
      o_pad_out          <= pad_out_d;
      o_pad_oe_n         <= pad_oe_n_d;
      o_periph_in        <= i_pad_in;
      o_second_shared_in <= i_pad_in[27:24];
      o_periph_sel       <= periph_sel;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  AST_HOST_OFF_GPIO: assert property (
    !regs_q.host_en |=> o_pad_oe_n[15:0] == ~$past(regs_q.dir[15:0]))
    else $error("host pads not gpio while host port off");

  AST_HOST_ON_OWNS: assert property (
    regs_q.host_en |=> o_pad_out[8:0] == $past(i_periph_out[8:0]))
    else $error("host port lost a pad it must own");

  AST_FIVE_FREE_ONLY: assert property (
    (regs_q.host_allow & ~gpio_pkg::HOST_FREE_MASK) == 16'h0000)
    else $error("host pad outside the five released");

  AST_TIMER_DRIVE: assert property (
    !regs_q.ctrl[24] && regs_q.dir[40]
      |=> !o_pad_oe_n[36] && o_pad_out[36] == $past(regs_q.data[40]))
    else $error("timer gpio output not driven from data");

  AST_TIMER_TRI: assert property (
    !regs_q.ctrl[24] && !regs_q.dir[40] |=> o_pad_oe_n[36])
    else $error("timer gpio input pad driven");

  AST_PERIPH_OWNS: assert property (
    regs_q.ctrl[0] |=> o_pad_oe_n[16] == $past(i_periph_oe_n[16]))
    else $error("peripheral enable not on pad");

  AST_SHARED_SECOND: assert property (
    regs_q.ctrl[20] && !regs_q.ctrl[8] |=> o_pad_out[24] == $past(i_second_shared_out[0]))
    else $error("second audio port not on shared pad");

  AST_SHARED_C_FIRST: assert property (
    !regs_q.ctrl[8] && !regs_q.ctrl[20] && regs_q.dir[24]
      |=> o_pad_out[24] == $past(regs_q.data[24]))
    else $error("group c gpio lost shared pad");

  AST_READ_PIN: assert property (
    i_wb.cyc && i_wb.stb && !ack_q && !i_wb.we && !regs_q.dir[40]
      && i_wb.adr == gpio_pkg::TIMER_DATA_REG_OFF
      |=> o_wb_ack && o_wb_dat[0] == $past(o_periph_in[36]))
    else $error("gpio input read not pad level");

  AST_ACK_ONE_CYCLE: assert property (
    o_wb_ack |=> !o_wb_ack)
    else $error("bus ack stood longer than one cycle");

  AST_ACK_AFTER_REQ: assert property (
    i_wb.cyc && i_wb.stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus request not acknowledged");

  AST_NO_ACK_IDLE: assert property (
    !i_wb.cyc && !o_wb_ack |=> !o_wb_ack)
    else $error("bus ack without request");

  AST_UNMAPPED_READ: assert property (
    i_wb.cyc && i_wb.stb && !ack_q && !i_wb.we && i_wb.adr[6:4] > 3'h4
      |=> o_wb_dat == 32'h00000000)
    else $error("unmapped read not zero");

  AST_HOST_OFF_SEL: assert property (
    !regs_q.host_en |=> o_periph_sel[15:0] == 16'h0000)
    else $error("host pad owned while host port off");

  AST_HOST_ON_SEL: assert property (
    regs_q.host_en |=> (o_periph_sel[15:0] | gpio_pkg::HOST_FREE_MASK) == 16'hFFFF)
    else $error("host port released a pad it must own");

  AST_HOST_FREE_GPIO: assert property (
    regs_q.host_en && regs_q.host_allow[9] && regs_q.dir[9]
      |=> !o_pad_oe_n[9] && o_pad_out[9] == $past(regs_q.data[9]))
    else $error("released host pad not driven from gpio");

  AST_GRP_C_GPIO_DRIVE: assert property (
    !regs_q.ctrl[0] && regs_q.dir[16]
      |=> !o_pad_oe_n[16] && o_pad_out[16] == $past(regs_q.data[16]))
    else $error("group c gpio output not driven");

  AST_GRP_D_OWNS: assert property (
    regs_q.ctrl[12]
      |=> o_pad_oe_n[28] == $past(i_periph_oe_n[28]) && o_pad_out[28] == $past(i_periph_out[28]))
    else $error("audio transmitter not on its pad");

  AST_GRP_E_OWNS: assert property (
    regs_q.ctrl[14] |=> o_pad_out[30] == $past(i_periph_out[30]))
    else $error("second audio port not on its own pad");

  AST_TIMER_OWNS: assert property (
    regs_q.ctrl[24] |=> o_pad_oe_n[36] == $past(i_periph_oe_n[36]))
    else $error("timer peripheral not on its pad");

  AST_SHARED_FIRST_WINS: assert property (
    regs_q.ctrl[8] |=> o_pad_oe_n[24] == $past(i_periph_oe_n[24]))
    else $error("first audio port lost shared pad");

  AST_SHARED_E_GPIO: assert property (
    !regs_q.ctrl[8] && !regs_q.ctrl[20] && !regs_q.dir[24] && regs_q.dir[36]
      |=> !o_pad_oe_n[24] && o_pad_out[24] == $past(regs_q.data[36]))
    else $error("group e gpio not on shared pad");

  AST_SHARED_TRI: assert property (
    !regs_q.ctrl[8] && !regs_q.ctrl[20] && !regs_q.dir[24] && !regs_q.dir[36]
      |=> o_pad_oe_n[24])
    else $error("shared input pad driven");

  AST_PERIPH_IN: assert property (
    1'b1 |=> o_periph_in == $past(i_pad_in))
    else $error("pad level not passed to peripherals");

  AST_SECOND_IN: assert property (
    1'b1 |=> o_second_shared_in == $past(i_pad_in[27:24]))
    else $error("shared pad level not passed to second port");

endmodule // shared_pin_gpio_ports

/* File: sim/shared_pin_gpio_ports_tb_top.sv */
// self-checking bench for the shared-pin gpio block
// assumes the gpio package and the design module are compiled first
module shared_pin_gpio_ports_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // stimulus and design
  // ----------------------------------------------------------------
  logic                 core_clk = 1'b0;
  logic                 rst      = 1'b1;
  gpio_pkg::wb_req_type wb_r     = '0;
  logic                 wb_ack;
  logic [31:0]          wb_dat;
  logic [36:0]          pad_in = '0, pad_out, pad_oe_n, periph_out = '0, periph_oe_n = '1;
  logic [36:0]          periph_in;
  logic [3:0]           sec_out = '0, sec_oe_n = '1, sec_in;
  logic [40:0]          periph_sel;
  logic [32:0]          exp_q[$];
  logic [32:0]          note;
  logic [31:0]          seed = 32'h00000028;
  logic [31:0]          v[5];
  int                   fails = 0, comparisons = 0, cycles = 0;
  always #50 core_clk = ~core_clk;
  shared_pin_gpio_ports i_shared_pin_gpio_ports (
    .i_core_clk(core_clk), .i_rst(rst), .i_wb(wb_r), .o_wb_ack(wb_ack), .o_wb_dat(wb_dat),
    .i_pad_in(pad_in), .o_pad_out(pad_out), .o_pad_oe_n(pad_oe_n),
    .i_periph_out(periph_out), .i_periph_oe_n(periph_oe_n),
    .i_second_shared_out(sec_out), .i_second_shared_oe_n(sec_oe_n),
    .o_periph_in(periph_in), .o_second_shared_in(sec_in), .o_periph_sel(periph_sel));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] expv);
    comparisons++;
    if (seen !== expv) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one classic cycle; a read notes its expected data
  task automatic wb(input logic w, input logic [6:0] a, input logic [31:0] d,
                    input logic [31:0] e);
    @(posedge core_clk);
    wb_r <= '{1'b1, 1'b1, w, 4'hF, a, d};
    exp_q.push_back({~w, e});
    do @(negedge core_clk); while (wb_ack !== 1'b1);
    @(posedge core_clk);
    wb_r.cyc <= 1'b0;
    wb_r.stb <= 1'b0;
  endtask
  // let a register write reach the pads
  task automatic settle();
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  always @(negedge core_clk) begin
    if (wb_ack === 1'b1) begin
      note = exp_q.pop_front();
      if (note[32]) check(wb_dat, note[31:0]);
    end
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    pad_in <= 37'({rnd(), rnd()});
    periph_out <= 37'({rnd(), rnd()});
    periph_oe_n <= 37'({rnd(), rnd()});
    sec_out <= 4'(rnd());
    sec_oe_n <= 4'(rnd());
    settle();
    check(pad_oe_n, {37{1'b1}});
    check(periph_sel, 41'h0);
    for (int g = 0; g < 5; g++) wb(1'b0, 7'(g << 4), 32'h0, 32'h0);
    $display("reset test done");
    // every group as outputs, then read back
    for (int g = 0; g < 5; g++) begin
      v[g] = rnd() & gpio_pkg::GRP_MASK[g];
      wb(1'b1, 7'(g << 4) + 7'h04, gpio_pkg::GRP_MASK[g], 32'h0);
      wb(1'b1, 7'(g << 4) + 7'h08, v[g], 32'h0);
      wb(1'b0, 7'(g << 4) + 7'h04, 32'h0, gpio_pkg::GRP_MASK[g]);
      wb(1'b0, 7'(g << 4) + 7'h08, 32'h0, v[g]);
    end
    settle();
    check(pad_out, {v[4][0], v[3][5:0], v[2][1:0], v[1][11:0], v[0][15:0]});
    check(pad_oe_n, 37'h0);
    wb(1'b0, 7'h50, 32'h0, gpio_pkg::UNMAPPED_READ);
    $display("group output test done");
    // host port on: only the five releasable pins stay gpio
    wb(1'b1, 7'h00, 32'h0001FFFF, 32'h0);
    wb(1'b0, 7'h00, 32'h0, 32'h0001E600);
    settle();
    check(pad_out[15:0], (periph_out[15:0] & 16'h19FF) | (v[0][15:0] & 16'hE600));
    check(pad_oe_n[15:0], periph_oe_n[15:0] & 16'h19FF);
    check(periph_sel[15:0], 16'h19FF);
    wb(1'b1, 7'h00, 32'h0, 32'h0);
    $display("host port test done");
    // timer pin handed to its peripheral
    wb(1'b1, 7'h40, 32'h1, 32'h0);
    settle();
    check({pad_out[36], pad_oe_n[36], periph_sel[40]}, {periph_out[36], periph_oe_n[36], 1'b1});
    $display("timer test done");
    // shared pads: second port gpio drives when first port gpio is input
    wb(1'b1, 7'h14, 32'h0FF, 32'h0);
    settle();
    check(pad_out[27:24], v[3][9:6]);
    check(pad_oe_n[27:24], 4'h0);
    wb(1'b1, 7'h10, 32'h101, 32'h0);
    settle();
    check({pad_out[24], pad_oe_n[24]}, {periph_out[24], periph_oe_n[24]});
    check({pad_out[16], pad_oe_n[16]}, {periph_out[16], periph_oe_n[16]});
    check(periph_sel[27:16], 12'h101);
    wb(1'b1, 7'h10, 32'h0, 32'h0);
    wb(1'b1, 7'h30, 32'h3C0, 32'h0);
    settle();
    check(pad_out[27:24], sec_out);
    check(pad_oe_n[27:24], sec_oe_n);
    check(sec_in, pad_in[27:24]);
    wb(1'b1, 7'h30, 32'h0, 32'h0);
    wb(1'b1, 7'h34, 32'h0, 32'h0);
    settle();
    check(pad_oe_n[27:24], 4'hF);
    wb(1'b0, 7'h18, 32'h0, {20'h0, pad_in[27:24], v[1][7:0]});
    wb(1'b0, 7'h38, 32'h0, {22'h0, pad_in[27:24], pad_in[35:30]});
    check(periph_in, pad_in);
    $display("shared pad test done");
    results();
  end
endmodule // shared_pin_gpio_ports_tb_top
